// >>> src/wdt_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------
// Register word indices, byte address is four times the index
// ----------------------------------------------------------------
`define WDT_CFG_INDEX 6'h00
`define WDT_STATUS_INDEX 6'h06

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WDT_EXPIRY_BIT 3
`define WDT_SLEEP_BIT 2
`define WDT_PSEL_LSB 0
`define WDT_PSEL_RESET 2'h3
`define WDT_PSEL_OFF 2'h0
`define WDT_PSEL_TIMER 2'h1
`define WDT_PSEL_WDT256 2'h2
`define WDT_PSEL_WDT1 2'h3

// ----------------------------------------------------------------
// Timing: nominal period in microseconds, RC tick period in ns
// ----------------------------------------------------------------
`define WDT_NOMINAL_US 12000
`define WDT_RC_TICK_NS 1000
`define WDT_BASE_TICKS ((`WDT_NOMINAL_US * 1000) / `WDT_RC_TICK_NS)
`define WDT_TIMER_OVF_TOSC 65536
`define WDT_PS_RATIO_MAX 256

`endif

// >>> src/wdt_pkg.sv
// Types shared by the watchdog design files.
package wdt_pkg;

  // Life-cycle states of the watchdog, one-hot.
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_RUN = 3'b010,
    ST_IN_RESET = 3'b100
  } wdt_state_type;

  // Operating modes decoded from the period select field.
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_TIMER = 2'h1,
    MODE_WDT256 = 2'h2,
    MODE_WDT1 = 2'h3
  } wdt_mode_type;

endpackage

// >>> src/wdt_counter.sv
// Base counter with postscaler, cleared by a clear event, producing an overflow strobe.
`timescale 1ns/1ns
module wdt_counter #(
  parameter int CNT_W = 16,
  parameter int PS_W = 8
) (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic clear, // Clears counter and postscaler.
  input wire logic inc, // Advances the counter by one.
  input wire logic [CNT_W-1:0] limit, // Last count value of the base counter.
  input wire logic [PS_W-1:0] ps_max, // Last postscaler value.
  output logic overflow, // Overflow strobe, combinational.
  output logic [CNT_W-1:0] count_value, // Base counter value.
  output logic [PS_W-1:0] ps_value // Postscaler value.
);

  logic [CNT_W-1:0] cnt_r;
  logic [PS_W-1:0] ps_r;

  // A clear beats an increment, so a clear never lets an overflow through.
  always_ff @(posedge ref_clk) begin
    if (!reset_n || clear) begin
      cnt_r <= '0;
      ps_r <= '0;
    end else if (inc) begin
      if (cnt_r == limit) begin
        cnt_r <= '0;
        ps_r <= (ps_r == ps_max) ? '0 : ps_r + 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Overflow fires on the increment that wraps both stages.
  assign overflow = reset_n && !clear && inc && (cnt_r == limit) && (ps_r == ps_max);
  assign count_value = cnt_r;
  assign ps_value = ps_r;

endmodule

// >>> src/wdt_top.sv
// Watchdog with plain overflow timer mode, power-up timer and Avalon-MM registers.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "wdt_regs.svh"

module wdt_top
  import wdt_pkg::*;
#(
  parameter int WDT_BASE_TICKS = `WDT_BASE_TICKS,
  parameter int TIMER_OVF_CYCLES = `WDT_TIMER_OVF_TOSC,
  parameter int PS_RATIO = `WDT_PS_RATIO_MAX
) (
  input wire logic ref_clk, // System and device clock, 100 MHz.
  input wire logic reset_n, // Power-on reset, synchronous, active low.
  input wire logic core_in_reset, // Device held in reset state by the core.
  input wire logic rc_osc_tick, // One pulse per private RC oscillator period.
  input wire logic watchdog_clear_instr, // Clear instruction executed, pulse.
  input wire logic sleep_instr, // Sleep instruction executed, pulse.
  input wire logic wake_irq, // Wake-up from sleep by interrupt, pulse.
  input wire logic in_sleep, // Device is in sleep, level.
  input wire logic [7:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes of a write.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Low for the cycle that completes a request.
  output logic powerup_hold, // Holds the device in reset during power-up.
  output logic wdt_reset_req, // One-cycle device reset request on time-out.
  output logic expiry_flag_n, // Active-low expiry flag.
  output logic sleep_entered_flag_n // Active-low sleep-entered flag.
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (WDT_BASE_TICKS < 2 || WDT_BASE_TICKS > 65536) begin : g_chk_base
    $error("WDT_BASE_TICKS must lie in 2..65536");
  end
  if (TIMER_OVF_CYCLES < 2 || TIMER_OVF_CYCLES > 65536) begin : g_chk_timer
    $error("TIMER_OVF_CYCLES must lie in 2..65536");
  end
  if (PS_RATIO < 1 || PS_RATIO > 256) begin : g_chk_ps
    $error("PS_RATIO must lie in 1..256");
  end

  localparam logic [15:0] BASE_LIMIT = 16'(WDT_BASE_TICKS - 1);
  localparam logic [15:0] TIMER_LIMIT = 16'(TIMER_OVF_CYCLES - 1);
  localparam logic [7:0] PS_LAST = 8'(PS_RATIO - 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Maps the period select code onto an operating mode.
  function automatic wdt_mode_type decode_mode(input logic [1:0] sel);
    case (sel)
      `WDT_PSEL_TIMER: decode_mode = MODE_TIMER;
      `WDT_PSEL_WDT256: decode_mode = MODE_WDT256;
      `WDT_PSEL_WDT1: decode_mode = MODE_WDT1;
      default: decode_mode = MODE_OFF;
    endcase
  endfunction

  // True when a byte address hits the word of the given index.
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] index);
    hit = (addr == {index, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wdt_state_type state_r;
  wdt_mode_type mode;
  logic [1:0] watchdog_period_select_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic powerup_hold_r;
  logic wdt_reset_r;
  logic expiry_r;
  logic sleep_flag_r;
  logic cnt_clear;
  logic cnt_inc;
  logic [15:0] cnt_limit;
  logic [7:0] cnt_ps_max;
  logic overflow;
  logic [15:0] count_value;
  logic [7:0] ps_value;
  logic wdt_mode;
  logic bus_take;

  assign mode = decode_mode(watchdog_period_select_r);
  assign wdt_mode = (mode == MODE_WDT1) || (mode == MODE_WDT256);
  assign bus_take = (avs_read || avs_write) && !waitrequest_r;

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------

  // Clear events: reset state, clear and sleep instructions, interrupt wake-up.
  assign cnt_clear = core_in_reset ||
                     (state_r == ST_RUN && (watchdog_clear_instr || sleep_instr)) ||
                     (state_r == ST_RUN && wake_irq);

  // Selects the count source and the terminal values; the reset state counts on its exit edge.
  always_comb begin
    cnt_inc = 1'b0;
    cnt_limit = BASE_LIMIT;
    cnt_ps_max = 8'h00;
    case (state_r)
      ST_POWERUP: begin
        cnt_inc = rc_osc_tick;
      end
      ST_RUN, ST_IN_RESET: begin
        case (mode)
          MODE_WDT1: begin
            cnt_inc = rc_osc_tick;
          end
          MODE_WDT256: begin
            cnt_inc = rc_osc_tick;
            cnt_ps_max = PS_LAST;
          end
          MODE_TIMER: begin
            cnt_inc = !in_sleep;
            cnt_limit = TIMER_LIMIT;
          end
          default: begin
            cnt_inc = 1'b0;
          end
        endcase
      end
      default: begin
        cnt_inc = 1'b0;
      end
    endcase
  end

  // Counter and postscaler have no bus path; only clear events reach them.
  wdt_counter #(
    .CNT_W(16),
    .PS_W(8)
  ) u_counter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clear(cnt_clear),
    .inc(cnt_inc),
    .limit(cnt_limit),
    .ps_max(cnt_ps_max),
    .overflow(overflow),
    .count_value(count_value),
    .ps_value(ps_value)
  );

  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------

  // Power-up timing, then running, with the device reset state tracked.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ST_POWERUP;
      powerup_hold_r <= 1'b1;
    end else begin
      case (state_r)
        ST_POWERUP: begin
          if (overflow) begin
            state_r <= ST_RUN;
            powerup_hold_r <= 1'b0;
          end
        end
        ST_RUN: begin
          if (core_in_reset) begin
            state_r <= ST_IN_RESET;
          end
        end
        ST_IN_RESET: begin
          if (!core_in_reset) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_POWERUP;
        end
      endcase
    end
  end

  // Time-out in watchdog mode raises a one-cycle device reset request.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wdt_reset_r <= 1'b0;
    end else begin
      wdt_reset_r <= overflow && (state_r == ST_RUN) && wdt_mode;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------

  // Expiry flag: only power-on reset presets it; an overflow beats a re-arm.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      expiry_r <= 1'b1;
    end else if (overflow && state_r == ST_RUN) begin
      expiry_r <= 1'b0;
    end else if (state_r == ST_RUN && (watchdog_clear_instr || sleep_instr)) begin
      expiry_r <= 1'b1;
    end
  end

  // Sleep flag: cleared by the sleep instruction, set again by a clear.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sleep_flag_r <= 1'b1;
    end else if (state_r == ST_RUN && sleep_instr) begin
      sleep_flag_r <= 1'b0;
    end else if (state_r == ST_RUN && watchdog_clear_instr) begin
      sleep_flag_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------

  // Waitrequest drops for one cycle after a request appears.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= !((avs_read || avs_write) && waitrequest_r);
    end
  end

  // Read data are loaded as waitrequest drops; unmapped words read zero.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read && waitrequest_r) begin
      readdata_r <= 32'h0000_0000;
      if (hit(avs_address, `WDT_CFG_INDEX)) begin
        readdata_r[`WDT_PSEL_LSB +: 2] <= watchdog_period_select_r;
      end else if (hit(avs_address, `WDT_STATUS_INDEX)) begin
        readdata_r[`WDT_EXPIRY_BIT] <= expiry_r;
        readdata_r[`WDT_SLEEP_BIT] <= sleep_flag_r;
      end
    end
  end

  // Period select is written on the completing edge; other writes are ignored.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      watchdog_period_select_r <= `WDT_PSEL_RESET;
    end else if (bus_take && avs_write && avs_byteenable[0] &&
                 hit(avs_address, `WDT_CFG_INDEX)) begin
      watchdog_period_select_r <= avs_writedata[`WDT_PSEL_LSB +: 2];
    end
  end

  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata = readdata_r;
  assign powerup_hold = powerup_hold_r;
  assign wdt_reset_req = wdt_reset_r;
  assign expiry_flag_n = expiry_r;
  assign sleep_entered_flag_n = sleep_flag_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  chk_rc_only_count: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_RUN && wdt_mode && !rc_osc_tick && !cnt_clear && !core_in_reset)
      |=> $stable(count_value))
    else $error("Watchdog counter moved without an RC tick.");

  chk_timeout_reset: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (overflow && state_r == ST_RUN && wdt_mode) |=> (wdt_reset_r && !expiry_r) ##1 !wdt_reset_r)
    else $error("Watchdog time-out did not give a one-cycle reset and flag.");

  chk_off_silent: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_RUN && mode == MODE_OFF) |-> !overflow)
    else $error("Disabled watchdog overflowed.");

  chk_clear_zeroes: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_RUN && (watchdog_clear_instr || sleep_instr || wake_irq))
      |=> (count_value == 16'h0000 && ps_value == 8'h00))
    else $error("Clear event left counter or postscaler nonzero.");

  chk_reset_held: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    core_in_reset [*2] |-> (count_value == 16'h0000 && ps_value == 8'h00))
    else $error("Counter ran while device held in reset.");

  chk_powerup_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_POWERUP && overflow) |=> !powerup_hold_r && state_r == ST_RUN)
    else $error("Power-up hold not released on first overflow.");

  chk_timer_no_reset: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (overflow && state_r == ST_RUN && mode == MODE_TIMER) |=> (!wdt_reset_r && !expiry_r))
    else $error("Timer overflow misbehaved.");

  chk_clear_rearms: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_RUN && mode == MODE_TIMER && watchdog_clear_instr && !overflow) |=> expiry_r)
    else $error("Clear instruction did not re-arm the expiry flag.");

  chk_sleep_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_RUN && mode == MODE_TIMER && in_sleep && !cnt_clear && !core_in_reset)
      |=> $stable(count_value))
    else $error("Timer counted during sleep.");

  chk_bus_answer: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ((avs_read || avs_write) && waitrequest_r) |=> !waitrequest_r ##1 waitrequest_r)
    else $error("Bus request not answered in one cycle.");

endmodule

// >>> verif/core_model.sv
// Model of the processor core and the private RC oscillator around the watchdog.
`timescale 1ns/1ns
module core_model (
  input wire logic ref_clk, // System clock.
  input wire logic wdt_reset_req, // Time-out reset request.
  input wire logic instr_go, // One-cycle request for an instruction pulse.
  input wire logic [1:0] instr_kind, // Instruction: 0 clear, 1 sleep, 2 wake.
  input wire logic hold_lvl, // Holds the device in its reset state.
  input wire logic sleep_lvl, // Puts the device to sleep.
  output logic rc_osc_tick, // RC tick, one clock in four.
  output logic watchdog_clear_instr, // Clear instruction pulse.
  output logic sleep_instr, // Sleep instruction pulse.
  output logic wake_irq, // Interrupt wake-up pulse.
  output logic in_sleep, // Device asleep.
  output logic core_in_reset // Device in reset state.
);
  logic [1:0] phase_r = 2'h0;
  logic [1:0] rst_cnt_r = 2'h0;
  // The RC oscillator runs free, in sleep too.
  always @(posedge ref_clk) begin
    phase_r <= phase_r + 2'h1;
    rc_osc_tick <= (phase_r == 2'h2);
  end
  // The core executes one instruction for each request, one cycle later.
  always @(posedge ref_clk) begin
    watchdog_clear_instr <= instr_go && (instr_kind == 2'h0);
    sleep_instr <= instr_go && (instr_kind == 2'h1);
    wake_irq <= instr_go && (instr_kind == 2'h2);
  end
  // The core sits in its reset state for a few cycles after a time-out.
  always @(posedge ref_clk) begin
    if (wdt_reset_req)
      rst_cnt_r <= 2'h3;
    else if (rst_cnt_r != 2'h0)
      rst_cnt_r <= rst_cnt_r - 2'h1;
  end
  assign in_sleep = sleep_lvl;
  assign core_in_reset = hold_lvl | (rst_cnt_r != 2'h0);
endmodule

// >>> verif/testbench.sv
// Self-checking testbench of the watchdog with its core model.
`timescale 1ns/1ns
module testbench;
  localparam int BT = 8;
  localparam int TC = 16;
  localparam int PR = 4;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, powerup_hold, wdt_reset_req, expiry_flag_n, sleep_entered_flag_n;
  logic rc_osc_tick, watchdog_clear_instr, sleep_instr, wake_irq, in_sleep, core_in_reset;
  logic instr_go = 1'b0;
  logic [1:0] instr_kind = 2'h0;
  logic hold_lvl = 1'b0;
  logic sleep_lvl = 1'b0;
  int bad_count = 0;
  int checked = 0;
  int req_seen = 0;
  int t;
  int n;
  // Clock and reset-request monitor.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wdt_reset_req === 1'b1) req_seen++;
  core_model core (.ref_clk(ref_clk), .wdt_reset_req(wdt_reset_req),
    .instr_go(instr_go), .instr_kind(instr_kind), .hold_lvl(hold_lvl), .sleep_lvl(sleep_lvl),
    .rc_osc_tick(rc_osc_tick), .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instr(sleep_instr), .wake_irq(wake_irq), .in_sleep(in_sleep),
    .core_in_reset(core_in_reset));
  wdt_top #(.WDT_BASE_TICKS(BT), .TIMER_OVF_CYCLES(TC), .PS_RATIO(PR)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .core_in_reset(core_in_reset),
    .rc_osc_tick(rc_osc_tick), .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instr(sleep_instr), .wake_irq(wake_irq), .in_sleep(in_sleep),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .powerup_hold(powerup_hold), .wdt_reset_req(wdt_reset_req),
    .expiry_flag_n(expiry_flag_n), .sleep_entered_flag_n(sleep_entered_flag_n));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits for the edge that samples waitrequest low, under a bound.
  task automatic wait_bus;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      check(1'b0, "bus stuck");
      complete_run();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [1:0] v, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {30'h0, v};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    wait_bus();
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_bus();
    check(avs_readdata === e, "read data");
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Counts ticks and clocks until: 0 reset request, 1 expiry flag low, 2 power-up end.
  task automatic run_to(input int kind);
    t = 0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (rc_osc_tick === 1'b1) t++;
    end while (!(kind == 0 && wdt_reset_req === 1'b1) && !(kind == 1 && expiry_flag_n === 1'b0)
      && !(kind == 2 && powerup_hold === 1'b0) && n < 2000);
    if (n >= 2000) begin
      check(1'b0, "event never came");
      complete_run();
    end
  endtask
  // One instruction pulse (0 clear, 1 sleep, 2 wake) placed between RC ticks.
  task automatic instr(input logic [1:0] kind);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rc_osc_tick !== 1'b1 && k < 8);
    if (k >= 8) begin
      check(1'b0, "no RC tick");
      complete_run();
    end
    instr_kind <= kind;
    instr_go <= 1'b1;
    @(posedge ref_clk);
    instr_go <= 1'b0;
    @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup;
    check(powerup_hold === 1'b1 && expiry_flag_n === 1'b1, "reset outputs");
    check(sleep_entered_flag_n === 1'b1, "sleep flag after reset");
    run_to(2);
    check(t == BT, "power-up length");
  endtask
  task automatic t_regs;
    bus_rd(8'h00, 32'h3);
    bus_wr(8'h00, 2'h0, 4'h1);
    bus_wr(8'h00, 2'h2, 4'h0);
    bus_rd(8'h00, 32'h0);
    bus_rd(8'h18, 32'hc);
    bus_wr(8'h18, 2'h0, 4'h1);
    bus_rd(8'h18, 32'hc);
    for (int a = 4; a < 24; a += 4) bus_rd(8'(a), 32'h0);
  endtask
  task automatic t_off;
    int k;
    instr(2'h0);
    k = req_seen;
    repeat (300) @(posedge ref_clk);
    check(req_seen == k && expiry_flag_n === 1'b1, "disabled watchdog fired");
  endtask
  task automatic t_clears;
    int k;
    instr(2'h0);
    bus_wr(8'h00, 2'h3, 4'h1);
    k = req_seen;
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge ref_clk);
      instr(2'(i % 3));
    end
    check(req_seen == k, "time-out despite clears");
    instr(2'h1);
    @(posedge ref_clk);
    check(sleep_entered_flag_n === 1'b0, "sleep flag not set");
    bus_rd(8'h18, 32'h8);
    instr(2'h0);
    @(posedge ref_clk);
    check(sleep_entered_flag_n === 1'b1, "sleep flag not cleared");
  endtask
  task automatic t_hold;
    int k;
    hold_lvl <= 1'b1;
    k = req_seen;
    repeat (200) @(posedge ref_clk);
    check(req_seen == k, "counted in reset state");
    hold_lvl <= 1'b0;
    run_to(0);
    check(t == BT, "restart after reset state");
  endtask
  task automatic t_wdt(input logic [1:0] code, input int exp);
    bus_wr(8'h00, code, 4'h1);
    sleep_lvl <= 1'b1;
    instr(2'h0);
    run_to(0);
    check(t == exp, "time-out length");
    check(expiry_flag_n === 1'b0, "expiry flag after time-out");
    repeat (8) @(posedge ref_clk);
    check(expiry_flag_n === 1'b0, "flag lost in reset state");
    sleep_lvl <= 1'b0;
    instr(2'h0);
    @(posedge ref_clk);
    check(expiry_flag_n === 1'b1, "clear did not re-arm");
  endtask
  task automatic t_timer;
    int k;
    bus_wr(8'h00, 2'h1, 4'h1);
    instr(2'h0);
    k = req_seen;
    run_to(1);
    check(n == TC + 1, "timer overflow length");
    check(req_seen == k, "timer reset the device");
    instr(2'h0);
    sleep_lvl <= 1'b1;
    @(posedge ref_clk);
    check(expiry_flag_n === 1'b1, "clear did not set flag");
    repeat (40) @(posedge ref_clk);
    check(expiry_flag_n === 1'b1, "timer ran in sleep");
    sleep_lvl <= 1'b0;
    run_to(1);
    check(n == TC + 1, "timer did not hold in sleep");
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_powerup();
    t_regs();
    t_off();
    t_clears();
    t_hold();
    t_wdt(2'h3, BT);
    t_wdt(2'h2, BT * PR);
    t_timer();
    complete_run();
  end
endmodule
